// *** common/rtc_pkg.sv ***
// shared constants, register map and types of the i2c calendar clock
// How it works
// - the target serves fast mode bus rates up to 400 kHz, no faster.
// - timekeeping registers stay frozen while a bus transfer is in progress.
// - a second falling due during the freeze is applied once the transfer ends.
// - day count rolls over by month length, february included, without help.
// - any year divisible by four is a leap year, no century exception.
// - a periodic interrupt fires every thirty or every sixty seconds.
// - register three holds one free scratch byte that timekeeping ignores.
// - the fast test bit in control register zero accelerates the counters.
// - target answers address byte a2 for writes and a3 for reads.
// - first written data byte loads the pointer; zero is control, four seconds.
// - reads follow pointer write, repeated start; seconds through year come out.
// - bit seven of seconds is the clock integrity flag; zero means reliable.
// - time and date fields are packed bcd, december being 12 hex.
// - writing 03 hex to control zero sets 12 hour mode and capacitor option.
// - in 12 hour mode a pm bit sits above the bcd hour, 23 is 3 pm.
// - the clock runs on without any restart or reset from the host.
// - offset register two trims one second every two hours or four minutes.
package rtc_pkg;
  // ==========================================================================
  // timing
  localparam int unsigned SYS_CLK_HZ    = 125_000_000;
  localparam int unsigned BUS_MAX_HZ    = 400_000;
  localparam int unsigned SCL_HALF_CYC  = SYS_CLK_HZ / (2 * BUS_MAX_HZ);
  localparam int unsigned SEC_TIME_S    = 1;
  localparam int unsigned SEC_CYC       = SYS_CLK_HZ * SEC_TIME_S;
  localparam int unsigned FAST_CYC      = 1024;
  localparam int unsigned CORR_STEP_CYC = 125;
  localparam int unsigned CORR_MODE0_S  = 7200;
  localparam int unsigned CORR_MODE1_S  = 240;
  // ==========================================================================
  // bus address and register map
  localparam logic [6:0] DEV_ADDR  = 7'h51;
  localparam logic [7:0] A_CTRL1   = 8'h00;
  localparam logic [7:0] A_CTRL2   = 8'h01;
  localparam logic [7:0] A_OFFSET  = 8'h02;
  localparam logic [7:0] A_SCRATCH = 8'h03;
  localparam logic [7:0] A_SEC     = 8'h04;
  localparam logic [7:0] A_MIN     = 8'h05;
  localparam logic [7:0] A_HOUR    = 8'h06;
  localparam logic [7:0] A_DAY     = 8'h07;
  localparam logic [7:0] A_WDAY    = 8'h08;
  localparam logic [7:0] A_MON     = 8'h09;
  localparam logic [7:0] A_YEAR    = 8'h0a;
  // ==========================================================================
  // field positions
  localparam int CTRL1_CAP  = 0;
  localparam int CTRL1_12H  = 1;
  localparam int CTRL1_TEST = 5;
  localparam int CTRL2_HALF = 4;
  localparam int CTRL2_MIN  = 5;
  localparam int OFS_MODE   = 7;
  localparam int SEC_FLAG   = 7;
  localparam int HOUR_PM    = 5;
  // ==========================================================================
  // values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SEC  = 8'h80;
  localparam logic [7:0] RST_ONE  = 8'h01;
  typedef enum logic [2:0] {
    B_IDLE, B_ADDR, B_ACK, B_WDATA, B_RDATA, B_RACK
  } bus_state_t;
endpackage

// *** verilog/bit_sync.sv ***
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module bit_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  // pin in, synchronised level out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  // idle bus level is high, so reset to ones
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= '1;
      q_o    <= '1;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
  if (W < 1) begin : g_chk
    $error("bit_sync width must be at least one");
  end
endmodule // bit_sync

// *** verilog/bcd_step.sv ***
// one packed bcd counter step with programmable bounds
`timescale 1ns/1ps
module bcd_step (
  // current value and bounds
  input  wire logic [7:0] val_i,
  input  wire logic [7:0] max_i,
  input  wire logic [7:0] min_i,
  // next value and roll-over
  output logic      [7:0] nxt_o,
  output logic            wrap_o
);
  // bcd orders like binary, so one compare finds the top
  always_comb begin
    wrap_o = (val_i >= max_i);
    if (wrap_o) begin
      nxt_o = min_i;
    end else if (val_i[3:0] >= 4'h9) begin
      nxt_o = {val_i[7:4] + 4'h1, 4'h0};
    end else begin
      nxt_o = val_i + 8'h01;
    end
  end
endmodule // bcd_step

// *** verilog/i2c_calendar_clock.sv ***
// i2c calendar clock: bus target, registers, time base and calendar
`timescale 1ns/1ps
module i2c_calendar_clock #(
  parameter int unsigned SEC_CYCLES  = rtc_pkg::SEC_CYC,
  parameter int unsigned FAST_CYCLES = rtc_pkg::FAST_CYC,
  parameter int unsigned CORR_STEP   = rtc_pkg::CORR_STEP_CYC
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // i2c pins, open drain
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n_o,
  // periodic interrupt
  output logic      int_n_o
);
  // ==========================================================================
  // elaboration checks
  if (rtc_pkg::SCL_HALF_CYC < 4) begin : g_bus_chk
    $error("system clock too slow for the bus rate");
  end
  if (FAST_CYCLES < 4 || SEC_CYCLES <= 64 * CORR_STEP + FAST_CYCLES) begin : g_cnt_chk
    $error("second length parameters out of range");
  end

  // ==========================================================================
  // declarations
  rtc_pkg::bus_state_t st_r;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic       rw_r;
  logic       first_r;
  logic       nack_r;
  logic [7:0] ptr_r;
  logic [7:0] ptr_inc;
  logic [7:0] rd_byte;
  logic       wr_stb;
  logic       busy_r;
  logic       pend_r;
  logic       tick;
  logic       apply;
  logic       sec_wr;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] offset_r;
  logic [7:0] scratch_r;
  logic [7:0] sec_r;
  logic [7:0] min_r;
  logic [7:0] hour_r;
  logic [7:0] day_r;
  logic [7:0] wday_r;
  logic [7:0] mon_r;
  logic [7:0] year_r;
  logic [31:0] div_r;
  logic [31:0] last_cnt;
  logic signed [31:0] adj;
  logic [12:0] csec_r;
  logic [12:0] csec_last;
  logic       adj_r;

  // ==========================================================================
  // pin sampling and bus conditions
  bit_sync #(.W(1)) u_scl_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       (scl_i),
    .q_o       (scl_s)
  );
  bit_sync #(.W(1)) u_sda_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .d_i       (sda_i),
    .q_o       (sda_s)
  );

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // 125 MHz gives over 150 samples per half period at 400 kHz
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start    = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop     = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ==========================================================================
  // pointer and read data
  assign ptr_inc = (ptr_r >= rtc_pkg::A_YEAR) ? 8'h00 : ptr_r + 8'h01;

  always_comb begin
    unique case (ptr_r)
      rtc_pkg::A_CTRL1:   rd_byte = ctrl1_r;
      rtc_pkg::A_CTRL2:   rd_byte = ctrl2_r;
      rtc_pkg::A_OFFSET:  rd_byte = offset_r;
      rtc_pkg::A_SCRATCH: rd_byte = scratch_r;
      rtc_pkg::A_SEC:     rd_byte = sec_r;
      rtc_pkg::A_MIN:     rd_byte = min_r;
      rtc_pkg::A_HOUR:    rd_byte = hour_r;
      rtc_pkg::A_DAY:     rd_byte = day_r;
      rtc_pkg::A_WDAY:    rd_byte = wday_r;
      rtc_pkg::A_MON:     rd_byte = mon_r;
      rtc_pkg::A_YEAR:    rd_byte = year_r;
      default:            rd_byte = 8'h00;
    endcase
  end

  assign wr_stb = scl_fall & (st_r == rtc_pkg::B_WDATA) & (bit_r == 4'h8) & ~first_r;
  assign sec_wr = wr_stb & (ptr_r == rtc_pkg::A_SEC);

  // ==========================================================================
  // bus target engine
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r       <= rtc_pkg::B_IDLE;
      sh_r       <= 8'h00;
      bit_r      <= 4'h0;
      rw_r       <= 1'b0;
      first_r    <= 1'b0;
      nack_r     <= 1'b0;
      ptr_r      <= 8'h00;
      sda_oe_n_o <= 1'b1;
    end else if (start) begin
      st_r       <= rtc_pkg::B_ADDR;
      bit_r      <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end else if (stop) begin
      st_r       <= rtc_pkg::B_IDLE;
      sda_oe_n_o <= 1'b1;
    end else if (scl_rise) begin
      if (st_r == rtc_pkg::B_ADDR || st_r == rtc_pkg::B_WDATA) begin
        sh_r  <= {sh_r[6:0], sda_s};
        bit_r <= bit_r + 4'h1;
      end else if (st_r == rtc_pkg::B_RDATA) begin
        bit_r <= bit_r + 4'h1;
      end else if (st_r == rtc_pkg::B_RACK) begin
        nack_r <= sda_s;
      end
    end else if (scl_fall) begin
      unique case (st_r)
        rtc_pkg::B_IDLE: begin
        end
        rtc_pkg::B_ADDR: begin
          if (bit_r == 4'h8) begin
            if (sh_r[7:1] == rtc_pkg::DEV_ADDR) begin
              st_r       <= rtc_pkg::B_ACK;
              rw_r       <= sh_r[0];
              first_r    <= ~sh_r[0];
              sda_oe_n_o <= 1'b0;
            end else begin
              st_r <= rtc_pkg::B_IDLE;
            end
          end
        end
        rtc_pkg::B_WDATA: begin
          if (bit_r == 4'h8) begin
            if (first_r) begin
              ptr_r <= sh_r;
            end else begin
              ptr_r <= ptr_inc;
            end
            first_r    <= 1'b0;
            st_r       <= rtc_pkg::B_ACK;
            sda_oe_n_o <= 1'b0;
          end
        end
        rtc_pkg::B_ACK: begin
          bit_r <= 4'h0;
          if (rw_r) begin
            st_r       <= rtc_pkg::B_RDATA;
            sh_r       <= rd_byte;
            sda_oe_n_o <= rd_byte[7];
          end else begin
            st_r       <= rtc_pkg::B_WDATA;
            sda_oe_n_o <= 1'b1;
          end
        end
        rtc_pkg::B_RDATA: begin
          if (bit_r == 4'h8) begin
            st_r       <= rtc_pkg::B_RACK;
            ptr_r      <= ptr_inc;
            sda_oe_n_o <= 1'b1;
          end else begin
            sh_r       <= {sh_r[6:0], 1'b0};
            sda_oe_n_o <= sh_r[6];
          end
        end
        rtc_pkg::B_RACK: begin
          if (nack_r) begin
            st_r <= rtc_pkg::B_IDLE;
          end else begin
            st_r       <= rtc_pkg::B_RDATA;
            bit_r      <= 4'h0;
            sh_r       <= rd_byte;
            sda_oe_n_o <= rd_byte[7];
          end
        end
      endcase
    end
  end

  // the pin only ever pulls low; the enable does the signalling
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ==========================================================================
  // freeze and pending second
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
    end else if (stop) begin
      busy_r <= 1'b0;
    end
  end

  // a single flag: a second access longer than one second loses ticks
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_r <= 1'b0;
    end else if (tick && busy_r) begin
      pend_r <= 1'b1;
    end else if (apply || sec_wr) begin
      pend_r <= 1'b0;
    end
  end

  assign apply = ~busy_r & (tick | pend_r);

  // ==========================================================================
  // time base with offset trim and fast test
  always_comb begin
    adj = 32'sd0;
    if (adj_r) begin
      adj = $signed({{25{offset_r[6]}}, offset_r[6:0]}) * $signed(CORR_STEP);
    end
    if (ctrl1_r[rtc_pkg::CTRL1_TEST]) begin
      last_cnt = FAST_CYCLES - 1;
    end else begin
      last_cnt = 32'($signed(SEC_CYCLES) - adj - 32'sd1);
    end
  end

  assign tick      = (div_r >= last_cnt);
  assign csec_last = offset_r[rtc_pkg::OFS_MODE] ? 13'(rtc_pkg::CORR_MODE1_S - 1)
                                                 : 13'(rtc_pkg::CORR_MODE0_S - 1);

  // free running divider, restarted only by a seconds write
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= 32'h0000_0000;
    end else if (sec_wr || tick) begin
      div_r <= 32'h0000_0000;
    end else begin
      div_r <= div_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      csec_r <= 13'h0000;
      adj_r  <= 1'b0;
    end else if (tick) begin
      adj_r  <= (csec_r >= csec_last);
      csec_r <= (csec_r >= csec_last) ? 13'h0000 : csec_r + 13'h0001;
    end
  end

  // ==========================================================================
  // control and scratch registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl1_r   <= rtc_pkg::RST_ZERO;
      ctrl2_r   <= rtc_pkg::RST_ZERO;
      offset_r  <= rtc_pkg::RST_ZERO;
      scratch_r <= rtc_pkg::RST_ZERO;
    end else if (wr_stb) begin
      if (ptr_r == rtc_pkg::A_CTRL1) ctrl1_r <= sh_r;
      if (ptr_r == rtc_pkg::A_CTRL2) ctrl2_r <= sh_r;
      if (ptr_r == rtc_pkg::A_OFFSET) offset_r <= sh_r;
      if (ptr_r == rtc_pkg::A_SCRATCH) scratch_r <= sh_r;
    end
  end

  // ==========================================================================
  // calendar
  logic [7:0] s_n, m_n, h_n, d_n, w_n, mo_n, y_n;
  logic       s_w, m_w, h_w, d_w, w_w, mo_w, y_w;
  logic       mode12, leap, h11, day_c, mon_c, yr_c;
  logic [7:0] mdays;
  logic [7:0] floor_zero;
  logic [7:0] floor_one;

  // shared lower bounds of the counting fields
  assign floor_zero = 8'h00;
  assign floor_one  = 8'h01;

  assign mode12 = ctrl1_r[rtc_pkg::CTRL1_12H];
  assign h11    = (hour_r[4:0] == 5'h11);
  assign leap   = year_r[4] ? (year_r[3:0] == 4'h2 || year_r[3:0] == 4'h6)
                            : (year_r[3:0] == 4'h0 || year_r[3:0] == 4'h4 ||
                               year_r[3:0] == 4'h8);

  always_comb begin
    unique case (mon_r)
      8'h02:                      mdays = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: mdays = 8'h30;
      default:                    mdays = 8'h31;
    endcase
  end

  bcd_step u_sec (.val_i({1'b0, sec_r[6:0]}), .max_i(8'h59), .min_i(floor_zero),
                  .nxt_o(s_n), .wrap_o(s_w));
  bcd_step u_min (.val_i(min_r), .max_i(8'h59), .min_i(floor_zero),
                  .nxt_o(m_n), .wrap_o(m_w));
  bcd_step u_hour (.val_i(mode12 ? {3'b000, hour_r[4:0]} : hour_r),
                   .max_i(mode12 ? 8'h12 : 8'h23), .min_i(mode12 ? 8'h01 : 8'h00),
                   .nxt_o(h_n), .wrap_o(h_w));
  bcd_step u_day (.val_i(day_r), .max_i(mdays), .min_i(floor_one),
                  .nxt_o(d_n), .wrap_o(d_w));
  bcd_step u_wday (.val_i(wday_r), .max_i(8'h06), .min_i(floor_zero),
                   .nxt_o(w_n), .wrap_o(w_w));
  bcd_step u_mon (.val_i(mon_r), .max_i(8'h12), .min_i(floor_one),
                  .nxt_o(mo_n), .wrap_o(mo_w));
  bcd_step u_year (.val_i(year_r), .max_i(8'h99), .min_i(floor_zero),
                   .nxt_o(y_n), .wrap_o(y_w));

  // 11 pm to 12 am closes the day in 12 hour mode
  assign day_c = s_w & m_w & (mode12 ? (h11 & hour_r[rtc_pkg::HOUR_PM]) : h_w);
  assign mon_c = day_c & d_w;
  assign yr_c  = mon_c & mo_w;

  // increments and host writes never coincide: writes only happen while busy
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_r  <= rtc_pkg::RST_SEC;
      min_r  <= rtc_pkg::RST_ZERO;
      hour_r <= rtc_pkg::RST_ZERO;
      day_r  <= rtc_pkg::RST_ONE;
      wday_r <= rtc_pkg::RST_ZERO;
      mon_r  <= rtc_pkg::RST_ONE;
      year_r <= rtc_pkg::RST_ZERO;
    end else if (apply) begin
      sec_r <= {sec_r[rtc_pkg::SEC_FLAG], s_n[6:0]};
      if (s_w) min_r <= m_n;
      if (s_w && m_w) begin
        if (mode12) begin
          hour_r <= {2'b00, hour_r[rtc_pkg::HOUR_PM] ^ h11, h_n[4:0]};
        end else begin
          hour_r <= h_n;
        end
      end
      if (day_c) begin
        day_r  <= d_n;
        wday_r <= w_n;
      end
      if (mon_c) mon_r <= mo_n;
      if (yr_c) year_r <= y_n;
    end else if (wr_stb) begin
      if (ptr_r == rtc_pkg::A_SEC) sec_r <= sh_r;
      if (ptr_r == rtc_pkg::A_MIN) min_r <= {1'b0, sh_r[6:0]};
      if (ptr_r == rtc_pkg::A_HOUR) hour_r <= {2'b00, sh_r[5:0]};
      if (ptr_r == rtc_pkg::A_DAY) day_r <= {2'b00, sh_r[5:0]};
      if (ptr_r == rtc_pkg::A_WDAY) wday_r <= {5'h00, sh_r[2:0]};
      if (ptr_r == rtc_pkg::A_MON) mon_r <= {3'h0, sh_r[4:0]};
      if (ptr_r == rtc_pkg::A_YEAR) year_r <= sh_r;
    end
  end

  // ==========================================================================
  // periodic interrupt, low for one second
  logic int_hit;
  assign int_hit = (ctrl2_r[rtc_pkg::CTRL2_MIN] & s_w) |
                   (ctrl2_r[rtc_pkg::CTRL2_HALF] & (s_w | (sec_r[6:0] == 7'h29)));

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_n_o <= 1'b1;
    end else if (apply) begin
      int_n_o <= ~int_hit;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_release;
    pend_r && !busy_r;
  endsequence
  sequence s_applied;
    !pend_r && (sec_r[6:0] != $past(sec_r[6:0]));
  endsequence

  freeze_hold_a: assert property (busy_r && !sec_wr |=> sec_r == $past(sec_r))
    else $error("seconds moved during a transfer");
  pend_catch_a: assert property (busy_r && tick |=> pend_r)
    else $error("second due in freeze was dropped");
  pend_apply_a: assert property (s_release |=> s_applied)
    else $error("pending second not applied after transfer");
  leap_feb_a: assert property (apply && day_c && mon_r == 8'h02 && day_r == 8'h28 &&
                               year_r == 8'h04 |=> day_r == 8'h29)
    else $error("leap february did not reach 29");
  month_end_a: assert property (apply && day_c && mon_r == 8'h02 && day_r == 8'h28 &&
                                year_r == 8'h03 |=> day_r == 8'h01 && mon_r == 8'h03)
    else $error("short february did not end on the 28th");
  int_minute_a: assert property (apply && ctrl2_r[rtc_pkg::CTRL2_MIN] && s_w
                                 |=> (!int_n_o)[*2])
    else $error("minute interrupt missing");
  scratch_keep_a: assert property (wr_stb && ptr_r == rtc_pkg::A_SCRATCH
                                   |=> scratch_r == $past(sh_r))
    else $error("scratch byte not stored");
  addr_reject_a: assert property (scl_fall && st_r == rtc_pkg::B_ADDR && bit_r == 4'h8 &&
                                  sh_r[7:1] != rtc_pkg::DEV_ADDR
                                  |=> st_r == rtc_pkg::B_IDLE && sda_oe_n_o)
    else $error("foreign address acknowledged");
  ptr_step_a: assert property (wr_stb && ptr_r == rtc_pkg::A_SEC
                               |=> ptr_r == rtc_pkg::A_MIN)
    else $error("pointer did not advance");
  flag_keep_a: assert property (apply |=> sec_r[7] == $past(sec_r[7]))
    else $error("integrity flag changed by counting");
  pm_flip_a: assert property (s_w && m_w && apply && mode12 && h11
                              |=> hour_r[5] != $past(hour_r[5]))
    else $error("pm bit did not toggle at 11 to 12");
  fast_period_a: assert property (ctrl1_r[rtc_pkg::CTRL1_TEST] &&
                                  $past(ctrl1_r[rtc_pkg::CTRL1_TEST], 2)
                                  |-> div_r < FAST_CYCLES)
    else $error("fast test period exceeded");
endmodule // i2c_calendar_clock

// *** bench/i2c_host_model.sv ***
// bus controller model driving the calendar clock pins
`timescale 1ns/1ps
module i2c_host_model (
  // clock
  input  wire logic sys_clk_i,
  // bus pins, released level is high
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ========
  // bus clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // start is (1,0), stop is (0,1); the low phase lets the target let go first
  task automatic cond(input logic a, input logic b);
    scl_o <= 1'b0;
    wt(5);
    sda_o <= a;
    wt(2);
    scl_o <= 1'b1;
    wt(5);
    sda_o <= b;
    wt(5);
  endtask
  // data changes only while the bus clock is low, seen at the end of high
  task automatic bit_io(input logic b, output logic s);
    scl_o <= 1'b0;
    wt(2);
    sda_o <= b;
    wt(3);
    scl_o <= 1'b1;
    wt(5);
    s = sda_i;
  endtask
  // msb first, then the ninth bit: a is sent, k is seen
  task automatic byte_io(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
endmodule // i2c_host_model

// *** bench/i2c_calendar_clock_bench.sv ***
// self-checking bench of the i2c calendar clock
`timescale 1ns/1ps
module i2c_calendar_clock_bench;
  `define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
  typedef logic [7:0] bytes_t [$];
  // ========
  // clock, reset, pins
  logic       sys_clk_i;
  logic       nrst_i;
  logic       scl;
  logic       host_sda;
  logic       dev_sda;
  logic       sda_oe_n;
  logic       int_n;
  logic       sda_w;
  logic [7:0] rx [11];
  logic [7:0] q;
  logic       k;
  bytes_t     t;
  int         bad_count = 0;
  int         n_tests = 0;
  assign sda_w = host_sda & (sda_oe_n | dev_sda);
  i2c_calendar_clock #(.SEC_CYCLES(4000), .FAST_CYCLES(200), .CORR_STEP(8)) dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(dev_sda), .sda_oe_n_o(sda_oe_n), .int_n_o(int_n));
  i2c_host_model host (
    .sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
  // ========
  // access tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input bytes_t d);
    host.cond(1'b1, 1'b0);
    host.byte_io(8'ha2, 1'b1, q, k);
    `CHK("write address ack", 1'b0, k)
    host.byte_io(p, 1'b1, q, k);
    foreach (d[i])
      host.byte_io(d[i], 1'b1, q, k);
    host.cond(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [7:0] p, input bytes_t e);
    host.cond(1'b1, 1'b0);
    host.byte_io(8'ha2, 1'b1, q, k);
    host.byte_io(p, 1'b1, q, k);
    host.cond(1'b1, 1'b0);
    host.byte_io(8'ha3, 1'b1, q, k);
    foreach (e[i])
      host.byte_io(8'hff, i == e.size() - 1, rx[i], k);
    host.cond(1'b0, 1'b1);
    foreach (e[i])
      `CHK($sformatf("reg %0h", p + i), e[i], rx[i])
  endtask
  // ========
  // scenarios
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    bad_count++;
    end_of_test();
  end
  initial begin
    nrst_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    host.wt(5);
    rd(8'h04, '{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
    host.cond(1'b1, 1'b0);
    host.byte_io(8'ha4, 1'b1, q, k);
    `CHK("foreign ack", 1'b1, k)
    host.cond(1'b0, 1'b1);
    t = '{8'h03, 8'h00, 8'h00, 8'ha5, 8'h00, 8'h45, 8'h23, 8'h15, 8'h04, 8'h12, 8'h11};
    wr(8'h00, t);
    rd(8'h00, t);
    `CHK("int idle", 1'b1, int_n)
    t = '{8'h00, 8'h20, 8'h00, 8'h5a, 8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h04};
    wr(8'h00, t);
    host.cond(1'b1, 1'b0);
    // held over two due seconds on purpose, so one of them is lost
    host.wt(9000);
    host.cond(1'b0, 1'b1);
    rd(8'h04, '{8'h00, 8'h00, 8'h00, 8'h29, 8'h00, 8'h02, 8'h04});
    `CHK("int 60 s", 1'b0, int_n)
    t = '{8'h00, 8'h00, 8'h00, 8'h5a, 8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02, 8'h03};
    wr(8'h00, t);
    host.wt(4200);
    rd(8'h04, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h03});
    `CHK("int off", 1'b1, int_n)
    // fast test in 12 hour mode: 11 pm rolls to 12 am once the write ends, from a second that fell due in the freeze
    t = '{8'h23, 8'h00, 8'h00, 8'h5a, 8'h59, 8'h59, 8'h31, 8'h15, 8'h04, 8'h12, 8'h11};
    wr(8'h00, t);
    host.wt(1000);
    rd(8'h04, '{8'h05, 8'h00, 8'h12, 8'h16, 8'h05, 8'h12, 8'h11});
    end_of_test();
  end
endmodule // i2c_calendar_clock_bench
